// File: bls_pkg.sv
// constants, modes and led layout of the button and led supervisor
package bls_pkg;
  // ----------------------------------------------------------------
  // clock and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ       = 40000;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned LONG_PRESS_MS = 2000;
  localparam int unsigned TRIPLE_WIN_MS = 2000;
  localparam int unsigned SCAN_MS       = 1000;
  localparam int unsigned AUTO_TAIL_MS  = 3000;
  localparam int unsigned LAMP_TEST_MS  = 2000;
  localparam int unsigned CBF_DELAY_MS  = 150;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned SUP_PERIOD_MS = 1000;
  localparam int unsigned SUP_PULSE_US  = 100;
  localparam int unsigned SUP_PULSE_CYC = SUP_PULSE_US * CLK_MHZ;
  localparam int unsigned TRIPLE_COUNT  = 3;
  // ----------------------------------------------------------------
  // sizes and led layout
  // ----------------------------------------------------------------
  localparam int unsigned CW       = 32;
  localparam int unsigned N_SENS   = 15;
  localparam int unsigned N_BI     = 2;
  localparam int unsigned N_TRIP   = 4;
  localparam int unsigned N_DIP    = 16;
  localparam int unsigned SRC_W    = 4;
  localparam int unsigned N_LED    = 25;
  localparam int unsigned LED_SENS = 0;
  localparam int unsigned LED_BI   = 15;
  localparam int unsigned LED_BO   = 17;
  localparam int unsigned LED_HSO  = 18;
  localparam int unsigned LED_TRIP = 19;
  localparam int unsigned LED_PWR  = 23;
  localparam int unsigned LED_ERR  = 24;
  localparam logic [24:0] LED_OFF  = 25'h0000000;
  localparam logic [24:0] LED_ALL  = 25'h1FFFFFF;
  localparam logic [31:0] CNT_ZERO = 32'h00000000;
  localparam logic [31:0] CNT_ONE  = 32'h00000001;
  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_PWRUP, M_NORMAL, M_AUTO, M_CHECK} bls_mode_e;
endpackage

// File: bls_btn_if.sv
// press events from the button decoder to the supervisor
`timescale 1ns/1ps
interface bls_btn_if;
  logic long_press;
  logic short_press;
  logic triple_press;
  modport src  (output long_press, output short_press, output triple_press);
  modport sink (input long_press, input short_press, input triple_press);
endinterface

// File: bls_button.sv
// button synchroniser, debouncer and press decoder
`timescale 1ns/1ps
module bls_button
  import bls_pkg::*;
#(
  parameter int unsigned P_DEB_CYC  = DEBOUNCE_MS * CLK_KHZ,
  parameter int unsigned P_LONG_CYC = LONG_PRESS_MS * CLK_KHZ,
  parameter int unsigned P_WIN_CYC  = TRIPLE_WIN_MS * CLK_KHZ
)
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // raw button, low while pressed
  input  wire logic i_btn_n,
  // press events
  bls_btn_if.src    btn
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        pressed;
    logic [31:0] deb_cnt;
    logic [31:0] hold_cnt;
    logic        long_done;
    logic        win_act;
    logic [31:0] win_cnt;
    logic [1:0]  presses;
    logic        long_p;
    logic        short_p;
    logic        triple_p;
  } bls_btn_s;

  bls_btn_s q;
  bls_btn_s d;

  function automatic logic hit(input logic [31:0] c, input int unsigned lim);
    hit = (c >= 32'(lim - 1));
  endfunction

  always_comb
  begin
    d         = q;
    d.long_p  = 1'b0;
    d.short_p = 1'b0;
    d.triple_p = 1'b0;
    d.s1      = ~i_btn_n;
    d.s2      = q.s1;
    // debounce: level must differ for the whole filter time
    if (q.s2 != q.pressed)
    begin
      if (hit(q.deb_cnt, P_DEB_CYC))
      begin
        d.pressed = q.s2;
        d.deb_cnt = CNT_ZERO;
      end
      else
        d.deb_cnt = q.deb_cnt + CNT_ONE;
    end
    else
      d.deb_cnt = CNT_ZERO;
    // hold timing
    if (q.pressed)
    begin
      if (!q.long_done && hit(q.hold_cnt, P_LONG_CYC))
      begin
        d.long_p    = 1'b1;
        d.long_done = 1'b1;
      end
      else if (!q.long_done)
        d.hold_cnt = q.hold_cnt + CNT_ONE;
    end
    else
    begin
      d.hold_cnt  = CNT_ZERO;
      d.long_done = 1'b0;
    end
    if (!d.pressed && q.pressed && !q.long_done)
      d.short_p = 1'b1;
    // triple press window
    if (q.win_act)
    begin
      if (hit(q.win_cnt, P_WIN_CYC))
        d.win_act = 1'b0;
      else
        d.win_cnt = q.win_cnt + CNT_ONE;
    end
    if (d.pressed && !q.pressed)
    begin
      if (!q.win_act || hit(q.win_cnt, P_WIN_CYC))
      begin
        d.win_act = 1'b1;
        d.win_cnt = CNT_ZERO;
        d.presses = 2'h1;
      end
      else if (q.presses == 2'(TRIPLE_COUNT - 1))
      begin
        d.triple_p = 1'b1;
        d.win_act  = 1'b0;
        d.presses  = 2'h0;
      end
      else
        d.presses = q.presses + 2'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign btn.long_press   = q.long_p;
  assign btn.short_press  = q.short_p;
  assign btn.triple_press = q.triple_p;

  a_press_exclusive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.long_p |-> !q.short_p && !q.triple_p)
    else $error("long press coincides with another press event");

endmodule

// File: bls_top.sv
// front-panel supervisor: button modes, led indication, breaker-failure backup
`timescale 1ns/1ps
module bls_top
  import bls_pkg::*;
#(
  parameter int unsigned P_DEB_CYC     = DEBOUNCE_MS * CLK_KHZ,
  parameter int unsigned P_LONG_CYC    = LONG_PRESS_MS * CLK_KHZ,
  parameter int unsigned P_WIN_CYC     = TRIPLE_WIN_MS * CLK_KHZ,
  parameter int unsigned P_SCAN_CYC    = SCAN_MS * CLK_KHZ,
  parameter int unsigned P_TAIL_CYC    = AUTO_TAIL_MS * CLK_KHZ,
  parameter int unsigned P_LAMP_CYC    = LAMP_TEST_MS * CLK_KHZ,
  parameter int unsigned P_CBF_CYC     = CBF_DELAY_MS * CLK_KHZ,
  parameter int unsigned P_BLINK_CYC   = BLINK_HALF_MS * CLK_KHZ,
  parameter int unsigned P_SUP_PER_CYC = SUP_PERIOD_MS * CLK_KHZ
)
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // operator button, low while pressed
  input  wire logic                i_btn_n,
  // arc sensor channels
  input  wire logic [N_SENS-1:0]   i_sensor_light,
  input  wire logic [N_SENS-1:0]   i_sensor_present,
  input  wire logic [N_SENS-1:0]   i_sensor_fault,
  // binary inputs and connection counts
  input  wire logic [N_BI-1:0]     i_bi_active,
  input  wire logic [N_BI-1:0]     i_bi_loose,
  input  wire logic [SRC_W-1:0]    i_bi_src_count,
  // scheme outputs and configuration
  input  wire logic [N_TRIP-1:0]   i_trip_req,
  input  wire logic [N_TRIP-1:0]   i_cbf_target,
  input  wire logic                i_bo_req,
  input  wire logic                i_hso_req,
  input  wire logic                i_latch_mode,
  input  wire logic                i_light_oc_mode,
  input  wire logic                i_overcurrent,
  input  wire logic [N_DIP-1:0]    i_dip,
  // supervision
  input  wire logic                i_hw_fault,
  input  wire logic                i_supply_fail,
  // non-volatile memory contents at power-up
  input  wire logic [N_LED-1:0]    i_nv_led,
  input  wire logic [N_SENS-1:0]   i_nv_sens,
  input  wire logic [SRC_W-1:0]    i_nv_src,
  input  wire logic [N_DIP-1:0]    i_nv_dip,
  input  wire logic                i_nv_setup_done,
  // relay outputs
  output logic [N_TRIP-1:0]        o_trip,
  output logic [N_TRIP-1:0]        o_cbf_trip,
  output logic                     o_bo,
  output logic                     o_hso,
  output logic                     o_sf_energized,
  // front-panel leds
  output logic [N_LED-1:0]         o_led,
  // non-volatile memory writes
  output logic                     o_nv_wr,
  output logic [N_DIP-1:0]         o_nv_dip,
  output logic [N_SENS-1:0]        o_nv_sens,
  output logic [SRC_W-1:0]         o_nv_src,
  output logic                     o_nv_led_wr,
  output logic [N_LED-1:0]         o_nv_led
);

  typedef struct packed {
    bls_mode_e           mode;
    logic [31:0]         tmr;
    logic [31:0]         blink_cnt;
    logic                blink;
    logic [31:0]         sup_cnt;
    logic [N_SENS-1:0]   sens_lat;
    logic [N_TRIP-1:0]   trip_lat;
    logic                hso_lat;
    logic [N_SENS-1:0]   found_s;
    logic [N_BI-1:0]     found_b;
    logic [N_SENS-1:0]   st_sens;
    logic [SRC_W-1:0]    st_src;
    logic [N_DIP-1:0]    st_dip;
    logic                setup_done;
    logic [N_DIP-1:0]    dip_prev;
    logic                dip_moved;
    logic [6:0]          chk_left;
    logic [31:0]         cbf_cnt;
    logic [N_TRIP-1:0]   cbf_out;
    logic [N_TRIP-1:0]   trip;
    logic                bo;
    logic                high_speed_output;
    logic                sf;
    logic [N_LED-1:0]    led;
    logic                nv_wr;
    logic                nv_led_wr;
  } bls_state_s;

  bls_state_s q;
  bls_state_s d;

  bls_btn_if btn ();

  logic              clr;
  logic              tog;
  logic              sysfail;
  logic              mism;
  logic              fault;
  logic              cond;
  logic [N_SENS-1:0] unconf;
  logic [5:0]        n_new;
  logic [5:0]        n_old;
  logic [N_LED-1:0]  ledv;

  function automatic logic hit(input logic [31:0] c, input int unsigned lim);
    hit = (c >= 32'(lim - 1));
  endfunction

  function automatic logic [5:0] conn_total(input logic [N_SENS-1:0] s,
                                            input logic [SRC_W-1:0]  src);
    logic [5:0] n;
    n = {2'h0, src};
    for (int i = 0; i < N_SENS; i++)
      n = n + {5'h00, s[i]};
    conn_total = n;
  endfunction

  // ----------------------------------------------------------------
  // button decoder
  // ----------------------------------------------------------------
  bls_button #(
    .P_DEB_CYC  (P_DEB_CYC),
    .P_LONG_CYC (P_LONG_CYC),
    .P_WIN_CYC  (P_WIN_CYC)
  ) u_button (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_btn_n (i_btn_n),
    .btn     (btn.src)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.nv_wr     = 1'b0;
    d.nv_led_wr = 1'b0;
    clr         = 1'b0;
    // shared blink phase
    tog = hit(q.blink_cnt, P_BLINK_CYC);
    if (tog)
    begin
      d.blink_cnt = CNT_ZERO;
      d.blink     = ~q.blink;
    end
    else
      d.blink_cnt = q.blink_cnt + CNT_ONE;
    // once-per-second connection pulse on the bo and hso outputs
    if (hit(q.sup_cnt, P_SUP_PER_CYC))
      d.sup_cnt = CNT_ZERO;
    else
      d.sup_cnt = q.sup_cnt + CNT_ONE;
    // supervision status
    unconf  = i_sensor_present & ~q.st_sens;
    sysfail = i_hw_fault | i_supply_fail | (|i_sensor_fault);
    mism    = (|unconf) | (|i_bi_loose)
            | (q.setup_done && (i_dip != q.st_dip))
            | (q.setup_done && (i_bi_src_count != q.st_src));
    if (i_dip != q.dip_prev)
      d.dip_moved = 1'b1;
    d.dip_prev = i_dip;
    n_new = conn_total(q.found_s, i_bi_src_count);
    n_old = conn_total(q.st_sens, q.st_src);
    // operating mode
    case (q.mode)
      M_PWRUP:
      begin
        if (q.tmr == CNT_ZERO)
        begin
          d.sens_lat   = i_nv_led[LED_SENS +: N_SENS];
          d.trip_lat   = i_nv_led[LED_TRIP +: N_TRIP];
          d.hso_lat    = i_nv_led[LED_HSO];
          d.st_sens    = i_nv_sens;
          d.st_src     = i_nv_src;
          d.st_dip     = i_nv_dip;
          d.setup_done = i_nv_setup_done;
          d.dip_prev   = i_dip;
          d.dip_moved  = 1'b0;
        end
        if (hit(q.tmr, P_LAMP_CYC))
        begin
          d.mode = M_NORMAL;
          d.tmr  = CNT_ZERO;
        end
        else
          d.tmr = q.tmr + CNT_ONE;
      end
      M_NORMAL:
      begin
        if (btn.long_press)
        begin
          d.mode    = M_AUTO;
          d.tmr     = CNT_ZERO;
          d.found_s = '0;
          d.found_b = '0;
        end
        else if (btn.triple_press && q.setup_done)
        begin
          d.mode     = M_CHECK;
          d.chk_left = {conn_total(q.st_sens, i_bi_src_count), 1'b0};
        end
        else if (btn.short_press)
          clr = 1'b1;
      end
      M_AUTO:
      begin
        if (q.tmr < 32'(P_SCAN_CYC))
        begin
          d.found_s = q.found_s | i_sensor_present;
          d.found_b = q.found_b | ~i_bi_loose;
        end
        if (hit(q.tmr, P_SCAN_CYC + P_TAIL_CYC))
        begin
          d.mode = M_NORMAL;
          d.tmr  = CNT_ZERO;
          clr    = 1'b1;
          if (n_new >= n_old || q.dip_moved)
          begin
            d.st_sens    = q.found_s;
            d.st_src     = i_bi_src_count;
            d.st_dip     = i_dip;
            d.setup_done = 1'b1;
            d.dip_moved  = (i_dip != q.dip_prev);
            d.nv_wr      = 1'b1;
          end
        end
        else
          d.tmr = q.tmr + CNT_ONE;
      end
      M_CHECK:
      begin
        if (tog)
        begin
          if (q.chk_left <= 7'h01)
          begin
            d.mode     = M_NORMAL;
            d.chk_left = 7'h00;
          end
          else
            d.chk_left = q.chk_left - 7'h01;
        end
      end
      default:
        d.mode = M_NORMAL;
    endcase
    // indication latches: a new event wins over a clear in the same cycle
    d.sens_lat = (clr ? '0 : d.sens_lat) | i_sensor_light;
    d.trip_lat = (clr ? '0 : d.trip_lat) | i_trip_req;
    d.hso_lat  = (clr ? 1'b0 : d.hso_lat) | i_hso_req;
    if ({d.sens_lat, d.trip_lat, d.hso_lat} != {q.sens_lat, q.trip_lat, q.hso_lat})
      d.nv_led_wr = 1'b1;
    // trip, bo and hso relays follow the scheme regardless of setup, sf the supervision
    d.trip = i_trip_req | (i_latch_mode ? d.trip_lat : '0);
    d.bo   = i_bo_req | (q.sup_cnt < 32'(SUP_PULSE_CYC));
    d.high_speed_output  = i_hso_req | (q.sup_cnt < 32'(SUP_PULSE_CYC));
    d.sf   = !(sysfail | mism);
    // breaker-failure backup
    fault = (|i_sensor_light) && (!i_light_oc_mode || i_overcurrent);
    cond  = fault && ((|i_trip_req) || (|q.trip));
    if (!cond)
    begin
      d.cbf_cnt = CNT_ZERO;
      d.cbf_out = '0;
    end
    else if (hit(q.cbf_cnt, P_CBF_CYC))
      d.cbf_out = i_cbf_target;
    else
      d.cbf_out = '0;
    if (cond && !hit(q.cbf_cnt, P_CBF_CYC))
      d.cbf_cnt = q.cbf_cnt + CNT_ONE;
    // led picture
    ledv = LED_OFF;
    case (q.mode)
      M_PWRUP:
        ledv = LED_ALL;
      M_AUTO:
      begin
        ledv[LED_SENS +: N_SENS] = q.found_s | (~q.found_s & {N_SENS{q.blink}});
        ledv[LED_BI +: N_BI]     = q.found_b | (~q.found_b & {N_BI{q.blink}});
        ledv[LED_BO]             = q.blink;
        ledv[LED_HSO]            = q.blink;
      end
      M_CHECK:
      begin
        ledv[LED_SENS +: N_SENS] = q.st_sens & {N_SENS{q.blink}};
        ledv[LED_BI +: N_BI]     = {N_BI{q.blink}};
        ledv[LED_PWR]            = q.blink;
      end
      default:
      begin
        ledv[LED_SENS +: N_SENS] = q.sens_lat
                                 | ((i_sensor_fault | unconf) & {N_SENS{q.blink}});
        ledv[LED_BI +: N_BI]     = i_bi_active
                                 | (i_bi_loose & ~i_bi_active & {N_BI{q.blink}});
        ledv[LED_BO]             = i_bo_req;
        ledv[LED_HSO]            = q.hso_lat;
        ledv[LED_TRIP +: N_TRIP] = q.trip_lat;
        ledv[LED_PWR]            = 1'b1;
        ledv[LED_ERR]            = sysfail | (mism & q.blink);
      end
    endcase
    d.led = ledv;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      q      <= '0;
      q.mode <= M_PWRUP;
      q.sf   <= 1'b0;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_trip         = q.trip;
  assign o_cbf_trip     = q.cbf_out;
  assign o_bo           = q.bo;
  assign o_hso          = q.high_speed_output;
  assign o_sf_energized = q.sf;
  assign o_led          = q.led;
  assign o_nv_wr        = q.nv_wr;
  assign o_nv_dip       = q.st_dip;
  assign o_nv_sens      = q.st_sens;
  assign o_nv_src       = q.st_src;
  assign o_nv_led_wr    = q.nv_led_wr;
  assign o_nv_led       = q.led;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sf_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_hw_fault || i_supply_fail) |=> !o_sf_energized)
    else $error("failure relay stays energized on fault");

  a_sensor_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_sensor_light[0] |=> q.sens_lat[0] ##1 (o_led[LED_SENS] || $past(q.mode) != M_NORMAL))
    else $error("sensor indication not latched");

  a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.sens_lat[0] && q.mode == M_NORMAL && !btn.short_press && !btn.long_press)
      |=> q.sens_lat[0])
    else $error("light indication dropped without reset");

  a_short_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.mode == M_NORMAL && btn.short_press && !btn.long_press && !btn.triple_press
      && i_sensor_light == '0 && i_trip_req == '0 && !i_hso_req)
      |=> q.sens_lat == '0 && q.trip_lat == '0 && !q.hso_lat)
    else $error("short press did not clear indications");

  a_auto_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.mode == M_NORMAL && btn.long_press) |=> q.mode == M_AUTO && q.tmr == CNT_ZERO)
    else $error("long press did not start setup");

  a_check_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.mode == M_NORMAL && btn.triple_press && !q.setup_done) |=> q.mode != M_CHECK)
    else $error("connection check started before setup");

  a_nv_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.nv_wr |-> $past(q.mode) == M_AUTO && q.mode == M_NORMAL && o_nv_dip == $past(i_dip))
    else $error("setup store outside end of setup");

  a_cbf_delay: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|q.cbf_out) |-> q.cbf_cnt == 32'(P_CBF_CYC - 1))
    else $error("backup trip before full delay");

  a_cbf_both: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_light_oc_mode && !i_overcurrent) |=> q.cbf_cnt == CNT_ZERO && q.cbf_out == '0)
    else $error("backup timer ran without overcurrent");

  a_lamp_test: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.mode == M_PWRUP |=> o_led == LED_ALL)
    else $error("lamp test not showing all leds");

endmodule

// File: bls_button_model.sv
// operator push button model with contact bounce
`timescale 1ns/1ps
module bls_button_model
(
  // clock and request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  // button contact, low while pressed
  output logic            o_btn_n
);
  initial o_btn_n = 1'b1;
  // bounce on make and break, hold low in between
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      repeat (3)
      begin
        @(posedge i_clk);
        #1 o_btn_n = ~o_btn_n;
      end
      repeat (i_len) @(posedge i_clk);
      repeat (3)
      begin
        @(posedge i_clk);
        #1 o_btn_n = ~o_btn_n;
      end
    end
  end
endmodule

// File: testbench.sv
// self-checking bench of the front-panel supervisor
`timescale 1ns/1ps
module testbench;
  import bls_pkg::*;
  localparam int LAMP = 10;
  localparam int CBF  = 15;
  logic              clk, rst_n, go, hw, bo, high_speed_output, lm, ocm, oc, sfl, nsd, nv_wr, sf;
  logic              b, obo, ohso, nlw;
  logic [7:0]        len;
  wire               btn_n;
  logic [N_SENS-1:0] light, pres, flt, nsens, nvsens;
  logic [N_TRIP-1:0] treq, tgt, trip, cbf;
  logic [N_BI-1:0]   bia, bil;
  logic [SRC_W-1:0]  src, nsrc, nvsrc;
  logic [N_DIP-1:0]  dip, nv_dip, ndip;
  logic [N_LED-1:0]  led, nled, nvled;
  int                error_cnt, n_compared;

  bls_button_model pm (.i_clk(clk), .i_go(go), .i_len(len), .o_btn_n(btn_n));
  bls_top #(.P_DEB_CYC(4), .P_LONG_CYC(50), .P_WIN_CYC(60), .P_SCAN_CYC(20),
    .P_TAIL_CYC(30), .P_LAMP_CYC(LAMP), .P_CBF_CYC(CBF), .P_BLINK_CYC(4),
    .P_SUP_PER_CYC(8000)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_btn_n(btn_n), .i_sensor_light(light),
    .i_sensor_present(pres), .i_sensor_fault(flt), .i_bi_active(bia), .i_bi_loose(bil),
    .i_bi_src_count(src), .i_trip_req(treq), .i_cbf_target(tgt), .i_bo_req(bo),
    .i_hso_req(high_speed_output), .i_latch_mode(lm), .i_light_oc_mode(ocm), .i_overcurrent(oc),
    .i_dip(dip), .i_hw_fault(hw), .i_supply_fail(sfl), .i_nv_led(nled),
    .i_nv_sens(nsens), .i_nv_src(nsrc), .i_nv_dip(ndip), .i_nv_setup_done(nsd),
    .o_trip(trip), .o_cbf_trip(cbf), .o_bo(obo), .o_hso(ohso), .o_sf_energized(sf),
    .o_led(led), .o_nv_wr(nv_wr), .o_nv_dip(nv_dip), .o_nv_sens(nvsens), .o_nv_src(nvsrc),
    .o_nv_led_wr(nlw), .o_nv_led(nvled));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic press(input int n);
    len = n[7:0];
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(n + 30);
  endtask
  // whole led picture, widened for the compare task
  function automatic logic [31:0] panel();
    return {7'h00, led};
  endfunction
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lamp();
    cyc(4);
    chk("lamp", 32'h01FFFFFF, {7'h00, led});
    cyc(LAMP + 4);
    chk("idle", 32'h00800000, panel());
  endtask
  task automatic t_latch();
    light[3] = 1'b1;
    treq[1] = 1'b1;
    high_speed_output = 1'b1;
    cyc(1);
    chk("nv led wr", 32'h1, {31'h0, nlw});
    light = '0;
    treq = '0;
    high_speed_output = 1'b0;
    cyc(4);
    chk("sens led", 32'h1, {31'h0, led[3]});
    chk("nv led", 32'h1, {31'h0, nvled[3]});
    chk("trip led", 32'h1, {31'h0, led[LED_TRIP+1]});
    chk("hso led", 32'h1, {31'h0, led[LED_HSO]});
    chk("trip", 32'h0, {28'h0, trip});
    lm = 1'b1;
    cyc(2);
    chk("trip held", 32'h2, {28'h0, trip});
    press(10);
    chk("cleared", 32'h00800000, panel());
    chk("trip freed", 32'h0, {28'h0, trip});
    lm = 1'b0;
  endtask
  task automatic t_cbf(input logic mode, input logic ovc);
    ocm = mode;
    oc = ovc;
    light[0] = 1'b1;
    treq[0] = 1'b1;
    tgt = 4'h8;
    cyc(CBF - 2);
    chk("cbf early", 32'h0, {28'h0, cbf});
    cyc(6);
    chk("cbf", (mode && !ovc) ? 32'h0 : 32'h8, {28'h0, cbf});
    light = '0;
    treq = '0;
    cyc(3);
    chk("cbf off", 32'h0, {28'h0, cbf});
    ocm = 1'b0;
    oc = 1'b0;
    press(10);
  endtask
  task automatic t_err();
    hw = 1'b1;
    cyc(3);
    chk("err led", 32'h1, {31'h0, led[LED_ERR]});
    chk("sf", 32'h0, {31'h0, sf});
    hw = 1'b0;
    sfl = 1'b1;
    cyc(3);
    chk("sf supply", 32'h0, {31'h0, sf});
    sfl = 1'b0;
    flt = 15'h0004;
    cyc(3);
    b = led[2];
    chk("flt err led", 32'h1, {31'h0, led[LED_ERR]});
    cyc(4);
    chk("flt blink", 32'h1, {31'h0, b ^ led[2]});
    chk("flt err steady", 32'h1, {31'h0, led[LED_ERR]});
    flt = '0;
    cyc(3);
    chk("sf back", 32'h1, {31'h0, sf});
  endtask
  task automatic t_bio();
    bia = 2'h1;
    bil = 2'h2;
    bo = 1'b1;
    cyc(3);
    b = led[LED_BI+1];
    chk("bi led", 32'h1, {31'h0, led[LED_BI]});
    chk("bo led", 32'h1, {31'h0, led[LED_BO]});
    chk("sf loose", 32'h0, {31'h0, sf});
    cyc(4);
    chk("bi blink", 32'h1, {31'h0, b ^ led[LED_BI+1]});
    {bia, bil, bo} = '0;
    cyc(3);
  endtask
  task automatic t_auto();
    int k;
    pres = 15'h0001;
    src = 4'h3;
    press(70);
    for (k = 0; k < 200 && nv_wr !== 1'b1; k++)
      cyc(1);
    chk("nv wr", 32'h1, {31'h0, nv_wr});
    chk("nv dip", {16'h0, dip}, {16'h0, nv_dip});
    chk("nv sens", 32'h1, {17'h0, nvsens});
    chk("nv src", 32'h3, {28'h0, nvsrc});
    cyc(2);
    chk("setup end", 32'h00800000, panel());
  endtask
  // three short taps inside the window, then count power led blinks
  task automatic t_check();
    int k;
    int falls;
    logic p;
    falls = 0;
    for (k = 0; k < 3; k++)
    begin
      len = 8'h08;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      if (k < 2)
        cyc(24);
    end
    for (k = 0; k < 60; k++)
    begin
      p = led[LED_PWR];
      cyc(1);
      if (p && !led[LED_PWR])
        falls++;
    end
    chk("check blinks", 32'h4, falls);
  endtask
  // second reset with stored indications and setup
  task automatic t_restore();
    rst_n = 1'b0;
    nled = 25'h0100020;
    nsens = 15'h0001;
    nsrc = 4'h3;
    ndip = dip;
    nsd = 1'b1;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    chk("relamp", 32'h01FFFFFF, {7'h00, led});
    cyc(LAMP + 2);
    chk("restored", 32'h00900020, panel());
    chk("nv sens back", 32'h1, {17'h0, nvsens});
    chk("sf restored", 32'h1, {31'h0, sf});
    press(10);
  endtask
  task automatic t_pulse();
    int k;
    for (k = 0; k < 9000 && obo !== 1'b0; k++)
      cyc(1);
    chk("bo pulse end", 32'h0, {31'h0, obo});
    chk("hso pulse end", 32'h0, {31'h0, ohso});
    for (k = 0; k < 9000 && obo !== 1'b1; k++)
      cyc(1);
    for (k = 0; k < 9000 && obo === 1'b1; k++)
      cyc(1);
    chk("pulse width", SUP_PULSE_CYC, k);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    cyc(20000);
    error_cnt++;
    results();
  end
  initial
  begin
    {rst_n, go, hw, bo, high_speed_output, lm, ocm, oc, sfl, nsd, len} = '0;
    {light, pres, flt, nsens, treq, tgt, bia, bil, src, nsrc, nled} = '0;
    dip = 16'h00A5;
    ndip = 16'h005A;
    error_cnt = 0;
    n_compared = 0;
    cyc(5);
    rst_n = 1'b1;
    t_lamp();
    t_latch();
    t_cbf(1'b0, 1'b0);
    t_cbf(1'b1, 1'b0);
    t_cbf(1'b1, 1'b1);
    t_err();
    t_bio();
    t_auto();
    t_check();
    t_restore();
    t_pulse();
    results();
  end
endmodule
